// *** shared/cmc_pkg.sv ***
package cmc_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ      = 40_000_000;
  localparam int unsigned HOLDOFF_MS  = 25;
  localparam int unsigned HOLDOFF_CYC = HOLDOFF_MS * (CLK_HZ / 1000);
  localparam int unsigned POR_US      = 1000;
  localparam int unsigned POR_CYC     = POR_US * (CLK_HZ / 1_000_000);
  localparam int unsigned CNT_W       = 24;
  typedef logic [CNT_W-1:0] cmc_cnt_t;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int unsigned AXI_AW       = 4;
  localparam logic [3:0]  CTRL_OFF     = 4'h0;
  localparam logic [3:0]  STAT_OFF     = 4'h4;
  localparam int unsigned CTRL_NOCE    = 0;
  localparam int unsigned CTRL_INHIBIT = 1;
  localparam logic [1:0]  CTRL_RESET   = 2'h0;
  localparam int unsigned ST_MODE      = 0;
  localparam int unsigned ST_CUR       = 4;
  localparam int unsigned ST_PASS      = 8;
  localparam int unsigned ST_HOLD      = 9;
  localparam int unsigned ST_FAULT     = 10;
  localparam int unsigned ST_GOOD      = 11;
  localparam int unsigned ST_CHG       = 12;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_DECERR  = 2'h3;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    M_PWR_DOWN, M_SLEEP, M_POR, M_STANDBY, M_BEGIN, M_CHARGING, M_SUSPEND
  } cmc_mode_t;

  typedef enum logic [1:0] {
    CUR_OFF, CUR_SHORT, CUR_PRE, CUR_FAST
  } cmc_cur_t;

  typedef struct packed {
    logic in_above_pdwn;
    logic in_detect;
    logic in_above_out;
    logic batt_above_scind;
    logic batt_above_sc;
    logic batt_above_lowv;
    logic vreg_reached;
    logic temp_ok;
    logic charge_enable_n;
    logic timer_pin_open;
  } cmc_cmp_t;

  localparam int unsigned CMP_W = $bits(cmc_cmp_t);

endpackage

// *** hw/cmc_mode_ctrl.sv ***
// Overview of operation
// R1 - below short threshold: short-recovery current only
// R2 - between short and precharge: precharge current
// R3 - above precharge, no regulation: fast current
// R4 - power-down: all off, outputs high impedance
// R5 - sleep: charger off, status off, power-good absent
// R6 - input not detected: enter sleep from anywhere
// R7 - input detected in sleep: start por
// R8 - during por: status charger-off, power-good absent
// R9 - por end: comparators on, outputs live
// R10 - enable pin high after por: stand-by
// R11 - no enable pin: por straight to begin
// R12 - begin resets timers, then charging
// R13 - bad temperature: suspend, charger off, hold timers
// R14 - temperature valid again: resume charging
// R15 - timer pin open: pass-through behaviour
// R16 - after input loss keep charger on 25ms
// R17 - block reverse current during hold-off
// R18 - power-good follows input immediately, no filter; code uses the synchronised, filtered in_above_out
// R19 - below short-indication threshold: status both off; code keeps both driven during por
// R20 - comparators and pin sampled on the clock
`timescale 1ns/1ps
module cmc_mode_ctrl #(
  parameter int unsigned HOLDOFF_CYCLES = cmc_pkg::HOLDOFF_CYC,
  parameter int unsigned POR_CYCLES     = cmc_pkg::POR_CYC
) (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire cmc_pkg::cmc_cmp_t          comparators,
  input  wire logic [cmc_pkg::AXI_AW-1:0] awaddr,
  input  wire logic                       awvalid,
  output logic                            awready,
  input  wire logic [31:0]                wdata,
  input  wire logic [3:0]                 wstrb,
  input  wire logic                       wvalid,
  output logic                            wready,
  output logic [1:0]                      bresp,
  output logic                            bvalid,
  input  wire logic                       bready,
  input  wire logic [cmc_pkg::AXI_AW-1:0] araddr,
  input  wire logic                       arvalid,
  output logic                            arready,
  output logic [31:0]                     rdata,
  output logic [1:0]                      rresp,
  output logic                            rvalid,
  input  wire logic                       rready,
  output logic                            charge_status_a_oe,
  output logic                            charge_status_b_oe,
  output logic                            input_power_good_n_oe,
  output logic                            pass_switch_on,
  output logic                            charger_on,
  output cmc_pkg::cmc_cur_t               current_sel,
  output logic                            timers_reset,
  output logic                            timers_hold,
  output logic                            safety_clk_reset,
  output logic                            termination_en,
  output logic                            batt_detect_en,
  output logic                            reverse_block,
  output logic                            comparators_en,
  output logic                            blocks_reset
);

  // ---------------------------------------------------------------
  // parameter check
  // ---------------------------------------------------------------
  localparam int unsigned CNT_MAX = (1 << cmc_pkg::CNT_W) - 1;
  if (HOLDOFF_CYCLES == 0 || HOLDOFF_CYCLES > CNT_MAX ||
      POR_CYCLES == 0 || POR_CYCLES > CNT_MAX) begin : g_bad_param
    $error("cmc_mode_ctrl: counts must be 1 to counter maximum");
  end

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [cmc_pkg::CMP_W-1:0] s1_q, s2_q, s3_q, filt_q;
  cmc_pkg::cmc_cmp_t         sy;
  assign sy = cmc_pkg::cmc_cmp_t'(filt_q);

  // three stages, change taken when stages two and three agree
  for (genvar i = 0; i < cmc_pkg::CMP_W; i++) begin : g_sync
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        s1_q[i]   <= 1'b0;
        s2_q[i]   <= 1'b0;
        s3_q[i]   <= 1'b0;
        filt_q[i] <= 1'b0;
      end else begin
        s1_q[i] <= comparators[i]; // [R20]
        s2_q[i] <= s1_q[i];
        s3_q[i] <= s2_q[i];
        if (s2_q[i] == s3_q[i]) begin
          filt_q[i] <= s3_q[i]; // [R20]
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // register file and axi4-lite slave
  // ---------------------------------------------------------------
  logic [1:0]  ctrl_q;
  logic [31:0] status_w;
  logic        wr_go;
  logic [cmc_pkg::AXI_AW-1:0] aw_q;
  logic [31:0] wd_q;
  logic [3:0]  ws_q;

  // address and data are each held until both are present
  assign wr_go = !awready && !wready && !bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready  <= 1'b1;
      bvalid  <= 1'b0;
      bresp   <= cmc_pkg::RESP_OKAY;
      aw_q    <= '0;
      wd_q    <= '0;
      ws_q    <= '0;
    end else begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        aw_q    <= awaddr;
      end
      if (wvalid && wready) begin
        wready <= 1'b0;
        wd_q   <= wdata;
        ws_q   <= wstrb;
      end
      if (wr_go) begin
        bvalid <= 1'b1;
        bresp  <= (aw_q == cmc_pkg::CTRL_OFF || aw_q == cmc_pkg::STAT_OFF)
                  ? cmc_pkg::RESP_OKAY : cmc_pkg::RESP_DECERR;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // control register, low byte lane only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= cmc_pkg::CTRL_RESET;
    end else if (wr_go && aw_q == cmc_pkg::CTRL_OFF && ws_q[0]) begin
      ctrl_q <= wd_q[1:0];
    end
  end

  // read channel, one cycle answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= cmc_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rresp   <= cmc_pkg::RESP_OKAY;
      if (araddr == cmc_pkg::CTRL_OFF) begin
        rdata <= {30'h0, ctrl_q};
      end else if (araddr == cmc_pkg::STAT_OFF) begin
        rdata <= status_w;
      end else begin
        rdata <= '0;
        rresp <= cmc_pkg::RESP_DECERR;
      end
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // mode sequencer
  // ---------------------------------------------------------------
  cmc_pkg::cmc_mode_t mode_q, mode_d;
  cmc_pkg::cmc_cnt_t  por_cnt_q, hold_cnt_q;
  logic               en_req, active, fault;

  // enable pin honoured only where the variant has one
  assign en_req = (ctrl_q[cmc_pkg::CTRL_NOCE] || !sy.charge_enable_n) &&
                  !ctrl_q[cmc_pkg::CTRL_INHIBIT];
  assign active = mode_q == cmc_pkg::M_STANDBY ||
                  mode_q == cmc_pkg::M_BEGIN ||
                  mode_q == cmc_pkg::M_CHARGING ||
                  mode_q == cmc_pkg::M_SUSPEND;
  assign fault  = !sy.batt_above_scind;

  // next mode; supply loss overrides every state
  always_comb begin
    mode_d = mode_q;
    if (!sy.in_above_pdwn) begin
      mode_d = cmc_pkg::M_PWR_DOWN; // [R4]
    end else if (!sy.in_detect) begin
      mode_d = cmc_pkg::M_SLEEP; // [R5] [R6]
    end else begin
      case (mode_q)
        cmc_pkg::M_PWR_DOWN: mode_d = cmc_pkg::M_SLEEP;
        cmc_pkg::M_SLEEP:    mode_d = cmc_pkg::M_POR; // [R7]
        cmc_pkg::M_POR: begin
          if (por_cnt_q == '0) begin
            if (ctrl_q[cmc_pkg::CTRL_NOCE]) begin
              mode_d = cmc_pkg::M_BEGIN; // [R11]
            end else if (sy.charge_enable_n) begin
              mode_d = cmc_pkg::M_STANDBY; // [R10]
            end else begin
              mode_d = cmc_pkg::M_BEGIN;
            end
          end
        end
        cmc_pkg::M_STANDBY: begin
          if (en_req) begin
            mode_d = cmc_pkg::M_BEGIN; // [R10]
          end
        end
        cmc_pkg::M_BEGIN:    mode_d = cmc_pkg::M_CHARGING; // [R12]
        cmc_pkg::M_CHARGING: begin
          if (!en_req) begin
            mode_d = cmc_pkg::M_STANDBY;
          end else if (!sy.temp_ok) begin
            mode_d = cmc_pkg::M_SUSPEND; // [R13]
          end
        end
        cmc_pkg::M_SUSPEND: begin
          if (!en_req) begin
            mode_d = cmc_pkg::M_STANDBY;
          end else if (sy.temp_ok) begin
            mode_d = cmc_pkg::M_CHARGING; // [R14]
          end
        end
        default: mode_d = cmc_pkg::M_PWR_DOWN;
      endcase
    end
  end

  // mode register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= cmc_pkg::M_PWR_DOWN;
    end else begin
      mode_q <= mode_d;
    end
  end

  // power-on-reset delay, reloaded in every mode except por
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      por_cnt_q <= '0;
    end else if (mode_q != cmc_pkg::M_POR) begin
      por_cnt_q <= cmc_pkg::cmc_cnt_t'(POR_CYCLES - 1); // [R7]
    end else if (por_cnt_q != '0) begin
      por_cnt_q <= por_cnt_q - 1'b1; // [R8]
    end
  end

  // hold-off after input loss while charging, rides out ripple dips
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_cnt_q <= '0;
    end else if (mode_q == cmc_pkg::M_CHARGING &&
                 mode_d == cmc_pkg::M_SLEEP) begin
      hold_cnt_q <= cmc_pkg::cmc_cnt_t'(HOLDOFF_CYCLES); // [R16]
    end else if (mode_q == cmc_pkg::M_SLEEP && hold_cnt_q != '0) begin
      hold_cnt_q <= hold_cnt_q - 1'b1;
    end else begin
      hold_cnt_q <= '0;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  logic in_hold, run;
  cmc_pkg::cmc_cur_t cur_d;
  assign in_hold = mode_q == cmc_pkg::M_SLEEP && hold_cnt_q != '0;
  assign run     = mode_q == cmc_pkg::M_CHARGING || in_hold;

  // current level from the battery comparators
  always_comb begin
    cur_d = cmc_pkg::CUR_OFF;
    if (mode_q == cmc_pkg::M_CHARGING) begin
      if (!sy.batt_above_sc) begin
        cur_d = cmc_pkg::CUR_SHORT; // [R1]
      end else if (!sy.batt_above_lowv) begin
        cur_d = cmc_pkg::CUR_PRE; // [R2]
      end else begin
        cur_d = cmc_pkg::CUR_FAST; // [R3]
      end
    end else if (in_hold) begin
      cur_d = current_sel;
    end
  end

  // all pin and control outputs registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      charge_status_a_oe    <= 1'b0;
      charge_status_b_oe    <= 1'b0;
      input_power_good_n_oe <= 1'b0;
      pass_switch_on        <= 1'b0;
      charger_on            <= 1'b0;
      current_sel           <= cmc_pkg::CUR_OFF;
      timers_reset          <= 1'b0;
      timers_hold           <= 1'b0;
      safety_clk_reset      <= 1'b1;
      termination_en        <= 1'b0;
      batt_detect_en        <= 1'b0;
      reverse_block         <= 1'b0;
      comparators_en        <= 1'b0;
      blocks_reset          <= 1'b0;
    end else begin
      // por shows charger off; live status short-fault goes hi-z
      charge_status_a_oe <= mode_q == cmc_pkg::M_POR ||
                            (active && !fault); // [R8] [R9] [R19]
      charge_status_b_oe <= mode_q == cmc_pkg::M_POR ||
                            (active && !fault &&
                             mode_q != cmc_pkg::M_CHARGING); // [R19]
      input_power_good_n_oe <= active && sy.in_above_out; // [R18]
      pass_switch_on   <= run; // [R4] [R5] [R16]
      charger_on       <= run; // [R13] [R16]
      current_sel      <= cur_d;
      timers_reset     <= mode_q == cmc_pkg::M_BEGIN; // [R12]
      timers_hold      <= mode_q == cmc_pkg::M_SUSPEND; // [R13] [R14]
      safety_clk_reset <= sy.timer_pin_open || !(mode_q ==
                          cmc_pkg::M_CHARGING || mode_q ==
                          cmc_pkg::M_SUSPEND); // [R15]
      termination_en   <= active && !sy.timer_pin_open; // [R15]
      batt_detect_en   <= active && !sy.timer_pin_open; // [R15]
      reverse_block    <= in_hold; // [R17]
      comparators_en   <= active; // [R9]
      blocks_reset     <= mode_q == cmc_pkg::M_POR; // [R7]
    end
  end

  // status word seen by software
  always_comb begin
    status_w = '0;
    status_w[cmc_pkg::ST_MODE +: 3] = mode_q;
    status_w[cmc_pkg::ST_CUR +: 2]  = current_sel;
    status_w[cmc_pkg::ST_PASS]      = sy.timer_pin_open;
    status_w[cmc_pkg::ST_HOLD]      = in_hold;
    status_w[cmc_pkg::ST_FAULT]     = fault;
    status_w[cmc_pkg::ST_GOOD]      = input_power_good_n_oe;
    status_w[cmc_pkg::ST_CHG]       = charger_on;
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_pdwn;
    mode_q == cmc_pkg::M_PWR_DOWN |=> !charge_status_a_oe &&
      !charge_status_b_oe && !input_power_good_n_oe && !pass_switch_on;
  endproperty
  a_pdwn: assert property (p_pdwn) else $error("power-down output"); // [R4]

  property p_sleep;
    mode_q == cmc_pkg::M_SLEEP && hold_cnt_q == '0 |=> !charger_on &&
      !charge_status_a_oe && !input_power_good_n_oe;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep output"); // [R5]

  property p_to_sleep;
    sy.in_above_pdwn && !sy.in_detect |=> mode_q == cmc_pkg::M_SLEEP;
  endproperty
  a_to_sleep: assert property (p_to_sleep) else $error("no sleep"); // [R6]

  property p_por_start;
    mode_q == cmc_pkg::M_SLEEP && sy.in_above_pdwn && sy.in_detect |=>
      mode_q == cmc_pkg::M_POR && por_cnt_q == POR_CYCLES - 1 ##1
      blocks_reset;
  endproperty
  a_por_start: assert property (p_por_start) else $error("por"); // [R7]

  property p_por_ind;
    mode_q == cmc_pkg::M_POR |=> charge_status_a_oe &&
      charge_status_b_oe && !input_power_good_n_oe;
  endproperty
  a_por_ind: assert property (p_por_ind) else $error("por status"); // [R8]

  property p_por_end;
    mode_q == cmc_pkg::M_POR && por_cnt_q == '0 && sy.in_detect &&
      sy.in_above_pdwn |=> (mode_q == cmc_pkg::M_STANDBY) ==
      ($past(sy.charge_enable_n) &&
       !$past(ctrl_q[cmc_pkg::CTRL_NOCE])) ##1 comparators_en;
  endproperty
  a_por_end: assert property (p_por_end) else $error("por end"); // [R10]

  property p_begin;
    mode_q == cmc_pkg::M_BEGIN && sy.in_detect && sy.in_above_pdwn |=>
      mode_q == cmc_pkg::M_CHARGING && timers_reset;
  endproperty
  a_begin: assert property (p_begin) else $error("begin"); // [R12]

  property p_susp;
    mode_q == cmc_pkg::M_SUSPEND |=> timers_hold && !charger_on;
  endproperty
  a_susp: assert property (p_susp) else $error("suspend"); // [R13]

  property p_resume;
    mode_q == cmc_pkg::M_SUSPEND && sy.temp_ok && en_req &&
      sy.in_detect && sy.in_above_pdwn |=> mode_q == cmc_pkg::M_CHARGING;
  endproperty
  a_resume: assert property (p_resume) else $error("resume"); // [R14]

  property p_pass;
    sy.timer_pin_open |=> safety_clk_reset && !termination_en &&
      !batt_detect_en;
  endproperty
  a_pass: assert property (p_pass) else $error("pass-through"); // [R15]

  property p_hold;
    mode_q == cmc_pkg::M_CHARGING && !sy.in_detect && sy.in_above_pdwn
      ##1 sy.in_above_pdwn && !sy.in_detect |=> charger_on &&
      reverse_block;
  endproperty
  a_hold: assert property (p_hold) else $error("hold-off"); // [R16] [R17]

  property p_good;
    !sy.in_above_out |=> !input_power_good_n_oe;
  endproperty
  a_good: assert property (p_good) else $error("power good"); // [R18]

  property p_short;
    !sy.batt_above_scind |=> !charge_status_a_oe && !charge_status_b_oe;
  endproperty
  a_short: assert property (p_short) else $error("short status"); // [R19]

  property p_cur;
    mode_q == cmc_pkg::M_CHARGING |=> current_sel ==
      (!$past(sy.batt_above_sc) ? cmc_pkg::CUR_SHORT :
       !$past(sy.batt_above_lowv) ? cmc_pkg::CUR_PRE : cmc_pkg::CUR_FAST);
  endproperty
  a_cur: assert property (p_cur) else $error("current level"); // [R1] [R2] [R3]

  c_standby: cover property (mode_q == cmc_pkg::M_POR ##1
                             mode_q == cmc_pkg::M_STANDBY);
  c_suspend: cover property (mode_q == cmc_pkg::M_SUSPEND ##1
                             mode_q == cmc_pkg::M_CHARGING);
  c_hold:    cover property (in_hold);
  c_fast:    cover property (current_sel == cmc_pkg::CUR_FAST);

endmodule

// *** testbench/cmc_supply_model.sv ***
`timescale 1ns/1ps
// ---------------------------------------------------------------
// adapter, battery pack and status monitor
// ---------------------------------------------------------------
module cmc_supply_model #(
  parameter int PDWN_MV  = 2500,
  parameter int DT_MV    = 100,
  parameter int SCIND_MV = 1800,
  parameter int SC_MV    = 1400,
  parameter int LOWV_MV  = 3000,
  parameter int VREG_MV  = 4200
) (
  input  int                vin_mv,
  input  int                vbat_mv,
  input  wire logic         temp_ok,
  input  wire logic         charge_enable_n,
  input  wire logic         timer_pin_open,
  input  wire logic         charge_status_a_oe,
  input  wire logic         charge_status_b_oe,
  input  wire logic         input_power_good_n_oe,
  output cmc_pkg::cmc_cmp_t comparators,
  output logic              charge_status_a,
  output logic              charge_status_b,
  output logic              input_power_good_n
);
  // threshold comparators, battery sits on the output
  always_comb begin
    comparators.in_above_pdwn   = vin_mv > PDWN_MV;
    comparators.in_detect       = vin_mv > vbat_mv + DT_MV;
    comparators.in_above_out    = vin_mv > vbat_mv;
    comparators.batt_above_scind = vbat_mv > SCIND_MV;
    comparators.batt_above_sc    = vbat_mv > SC_MV;
    comparators.batt_above_lowv  = vbat_mv > LOWV_MV;
    comparators.vreg_reached    = vbat_mv >= VREG_MV;
    comparators.temp_ok         = temp_ok;
    comparators.charge_enable_n = charge_enable_n;
    comparators.timer_pin_open  = timer_pin_open;
  end
  // pull-ups on the open-drain lines
  assign charge_status_a    = charge_status_a_oe ? 1'b0 : 1'b1;
  assign charge_status_b    = charge_status_b_oe ? 1'b0 : 1'b1;
  assign input_power_good_n = input_power_good_n_oe ? 1'b0 : 1'b1;
endmodule

// *** testbench/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  localparam int unsigned HOLD = 20;
  localparam int unsigned POR  = 40;
  logic        aclk     = 1'b0;
  logic        aresetn  = 1'b0;
  logic [3:0]  awaddr   = 4'h0;
  logic        awvalid  = 1'b0;
  logic [31:0] wdata    = 32'h0;
  logic [3:0]  wstrb    = 4'h0;
  logic        wvalid   = 1'b0;
  logic        bready   = 1'b0;
  logic [3:0]  araddr   = 4'h0;
  logic        arvalid  = 1'b0;
  logic        rready   = 1'b0;
  logic        temp_ok  = 1'b1;
  logic        ce_n     = 1'b1;
  logic        tp_open  = 1'b0;
  int          vin      = 0;
  int          vbat     = 3700;
  int          n_fail   = 0;
  int          compares = 0;
  int          pulses   = 0;
  logic awready, wready, bvalid, arready, rvalid, a_oe, b_oe, good_oe;
  logic pass_on, chg_on, t_rst, t_hold, sck_rst, term_en, det_en;
  logic rev_blk, cmp_en, blk_rst, stat_a, stat_b, good_n;
  logic [1:0]  bresp, rresp, r;
  logic [31:0] rdata, d;
  logic [2:0]  md;
  cmc_pkg::cmc_cur_t cur;
  cmc_pkg::cmc_cmp_t cmp;

  // clock
  always #12.5 aclk = ~aclk;

  // ---------------------------------------------------------------
  // instances
  // ---------------------------------------------------------------
  cmc_mode_ctrl #(.HOLDOFF_CYCLES(HOLD), .POR_CYCLES(POR)) i_cmc_mode_ctrl (
    .aclk(aclk), .aresetn(aresetn), .comparators(cmp),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .charge_status_a_oe(a_oe), .charge_status_b_oe(b_oe),
    .input_power_good_n_oe(good_oe), .pass_switch_on(pass_on),
    .charger_on(chg_on), .current_sel(cur), .timers_reset(t_rst),
    .timers_hold(t_hold), .safety_clk_reset(sck_rst),
    .termination_en(term_en), .batt_detect_en(det_en),
    .reverse_block(rev_blk), .comparators_en(cmp_en),
    .blocks_reset(blk_rst));
  cmc_supply_model i_cmc_supply_model (
    .vin_mv(vin), .vbat_mv(vbat), .temp_ok(temp_ok),
    .charge_enable_n(ce_n), .timer_pin_open(tp_open),
    .charge_status_a_oe(a_oe), .charge_status_b_oe(b_oe),
    .input_power_good_n_oe(good_oe), .comparators(cmp),
    .charge_status_a(stat_a), .charge_status_b(stat_b),
    .input_power_good_n(good_n));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] s,
                     input logic [31:0] e);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %0h seen %0h", n, e, s);
    end
  endtask

  task automatic test_done;
    if (n_fail == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // wait n edges, counting timer reset pulses
  task automatic settle(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge aclk);
      if (t_rst === 1'b1) pulses++;
    end
  endtask

  task automatic sup(input int v, input int b);
    @(posedge aclk);
    vin <= v;
    vbat <= b;
    settle(8);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] x);
    @(posedge aclk);
    awaddr <= a;
    wdata <= x;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        r = bresp;
        bready <= 1'b0;
        return;
      end
    end
    chk("write timeout", 1, 0);
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        return;
      end
    end
    chk("read timeout", 1, 0);
  endtask

  task automatic get_mode;
    rd(cmc_pkg::STAT_OFF);
    md = d[2:0];
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_power_up;
    chk("reset", {a_oe, b_oe, good_oe, chg_on, cur, sck_rst}, 7'h01);
    sup(3000, 3700);
    get_mode;
    chk("mode sleep", md, cmc_pkg::M_SLEEP);
    chk("sleep pins", {stat_a, stat_b, good_n, chg_on}, 4'hE);
    sup(5000, 3700);
    chk("por outs", {a_oe, b_oe, good_oe, blk_rst}, 4'hD);
    settle(POR + 20);
    get_mode;
    chk("mode standby", md, cmc_pkg::M_STANDBY);
    chk("live outs", {good_n, cmp_en, chg_on}, 3'h2);
  endtask

  task automatic t_charge;
    pulses = 0;
    @(posedge aclk);
    ce_n <= 1'b0;
    settle(10);
    chk("timer reset pulses", pulses, 1);
    get_mode;
    chk("mode charging", md, cmc_pkg::M_CHARGING);
    chk("charging", {chg_on, pass_on, stat_a, stat_b, cur}, 6'h37);
  endtask

  task automatic t_current;
    int         bv[4] = '{1000, 1600, 2500, 3700};
    logic [3:0] ex[4] = '{4'h1, 4'h2, 4'hA, 4'hB};
    for (int i = 0; i < 4; i++) begin
      sup(5000, bv[i]);
      chk("current", {a_oe, b_oe, cur}, ex[i]);
    end
  endtask

  task automatic t_suspend;
    pulses = 0;
    @(posedge aclk);
    temp_ok <= 1'b0;
    settle(8);
    get_mode;
    chk("mode suspend", md, cmc_pkg::M_SUSPEND);
    chk("suspend", {chg_on, t_hold}, 2'h1);
    @(posedge aclk);
    temp_ok <= 1'b1;
    settle(8);
    get_mode;
    chk("mode resume", md, cmc_pkg::M_CHARGING);
    chk("timers kept", {pulses[3:0], chg_on, t_hold}, 6'h02);
  endtask

  task automatic t_pass;
    @(posedge aclk);
    tp_open <= 1'b1;
    settle(8);
    chk("pass-through", {sck_rst, term_en, det_en}, 3'h4);
    @(posedge aclk);
    tp_open <= 1'b0;
    settle(8);
    chk("termination back", term_en, 1'b1);
  endtask

  task automatic t_loss;
    sup(3700, 3700);
    chk("loss", {good_n, chg_on, pass_on, rev_blk}, 4'hF);
    get_mode;
    chk("mode loss", md, cmc_pkg::M_SLEEP);
    settle(HOLD + 10);
    chk("hold-off over", {chg_on, pass_on}, 2'h0);
  endtask

  task automatic t_variant;
    sup(0, 3700);
    get_mode;
    chk("mode off", md, cmc_pkg::M_PWR_DOWN);
    chk("off pins", {stat_a, stat_b, good_n, chg_on, pass_on}, 5'h1C);
    wr(cmc_pkg::CTRL_OFF, 32'h1);
    chk("ctrl bresp", r, cmc_pkg::RESP_OKAY);
    rd(cmc_pkg::CTRL_OFF);
    chk("ctrl read", d, 32'h1);
    rd(4'h8);
    chk("unmapped rresp", r, cmc_pkg::RESP_DECERR);
    chk("unmapped data", d, 32'h0);
    pulses = 0;
    @(posedge aclk);
    ce_n <= 1'b1;
    sup(5000, 3700);
    settle(POR + 20);
    get_mode;
    chk("variant mode", md, cmc_pkg::M_CHARGING);
    chk("variant begin", pulses, 1);
    wr(cmc_pkg::CTRL_OFF, 32'h3);
    settle(4);
    get_mode;
    chk("inhibit mode", md, cmc_pkg::M_STANDBY);
    chk("inhibit off", chg_on, 1'b0);
  endtask

  // ---------------------------------------------------------------
  // sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_power_up;
    t_charge;
    t_current;
    t_suspend;
    t_pass;
    t_loss;
    t_variant;
    test_done;
  end

  initial begin
    repeat (5000) @(posedge aclk);
    n_fail++;
    test_done;
  end
endmodule
